// *** udcd_defs.vh ***
// constants for the usb device command decoder
// Overview of operation
// - select line high takes command, low moves data
// - commands without data run at once
// - least significant byte moves first
// - codes 50-5F read endpoint 0-15 state
// - codes 61,62-6F validate IN buffers
// - codes 70,72-7F clear OUT buffers
// - codes 80-8F remove endpoint stall
// - codes D0-DF read state copy, no clear
// - code F4 acknowledges setup on endpoint zero
// - codes A0-AF read endpoint fault code
// - code B0 with two bytes unlocks registers
// - codes B2/B3 write/read two-byte spare storage
// - B4 frame, B5 identity, C0 four-byte flags
// - N bytes take (N+1)/2 words on 16-bit
// - upper byte ignored for 8-bit registers
// - usb bus reset disables every endpoint
// - allocate after all 16 configured in order
// - size/enable change invalidates all buffers
// - codes 20-2F write, 30-3F read setup
// - bit 7 enables endpoint buffer
// - bit 6 selects endpoint and dma direction
// - bit 5 double buffer, bit 4 isochronous
// - bits 3-0 size code, reset zero
`ifndef UDCD_DEFS_VH
`define UDCD_DEFS_VH
`define UDCD_GRP_SETUP_WR 4'h2
`define UDCD_GRP_SETUP_RD 4'h3
`define UDCD_GRP_STATE 4'h5
`define UDCD_GRP_VALIDATE 4'h6
`define UDCD_GRP_CLEAR 4'h7
`define UDCD_GRP_UNSTALL 4'h8
`define UDCD_GRP_FAULT 4'ha
`define UDCD_GRP_COPY 4'hd
`define UDCD_CMD_UNLOCK 8'hb0
`define UDCD_CMD_SPARE_WR 8'hb2
`define UDCD_CMD_SPARE_RD 8'hb3
`define UDCD_CMD_FRAME 8'hb4
`define UDCD_CMD_IDENT 8'hb5
`define UDCD_CMD_FLAGS 8'hc0
`define UDCD_CMD_SETUP_ACK 8'hf4
`define UDCD_BIT_ENABLE 7
`define UDCD_BIT_DIR 6
`define UDCD_BIT_DOUBLE 5
`define UDCD_BIT_ISO 4
`define UDCD_SETUP_RESET 8'h00
`define UDCD_SPARE_RESET 16'h0000
`define UDCD_LAST_EP 4'hf
`define UDCD_FIFO_DEPTH 8
`define UDCD_FIFO_AW 3
`endif

// *** udcd_fifo.v ***
// small valid/ready fifo for read data words
`timescale 1ns/1ps
module udcd_fifo #(
  parameter WIDTH = 16,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire clk,
  input wire reset,
  input wire [WIDTH-1:0] inData,
  input wire inValid,
  output wire inReady,
  output wire [WIDTH-1:0] outData,
  output wire outValid,
  input wire outReady
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wrPtr_reg;
  reg [AW-1:0] rdPtr_reg;
  reg [AW:0] count_reg;
  wire doWrite = inValid && inReady;
  wire doRead = outValid && outReady;
  assign inReady = (count_reg != DEPTH[AW:0]);
  assign outValid = (count_reg != {(AW+1){1'b0}});
  assign outData = mem[rdPtr_reg];
  always @(posedge clk) begin
    if (doWrite) begin
      mem[wrPtr_reg] <= inData;
    end
  end
  always @(posedge clk) begin
    if (reset) begin
      wrPtr_reg <= {AW{1'b0}};
      rdPtr_reg <= {AW{1'b0}};
      count_reg <= {(AW+1){1'b0}};
    end else begin
      if (doWrite) begin
        wrPtr_reg <= wrPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doRead) begin
        rdPtr_reg <= rdPtr_reg + {{(AW-1){1'b0}}, 1'b1};
      end
      if (doWrite && !doRead) begin
        count_reg <= count_reg + {{AW{1'b0}}, 1'b1};
      end else if (doRead && !doWrite) begin
        count_reg <= count_reg - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // udcd_fifo

// *** udcd_command_decoder.v ***
// command decoder: command and data phases, endpoint setup registers
`timescale 1ns/1ps
`include "udcd_defs.vh"
module udcd_command_decoder #(
  parameter [15:0] PART_IDENTITY = 16'h5a01 // value is arbitrary
) (
  input wire clk,
  input wire reset,
  input wire cmdSelect,
  input wire writeStrobe,
  input wire readStrobe,
  input wire wide16,
  input wire [15:0] dataIn,
  input wire usbBusReset,
  input wire [127:0] endpointStateIn,
  input wire [127:0] endpointFaultIn,
  input wire [10:0] frameCount,
  input wire [31:0] eventFlags,
  output reg [15:0] dataOut,
  output reg dataOutValid,
  output reg [15:0] validatePulse,
  output reg [15:0] clearPulse,
  output reg [15:0] unstallPulse,
  output reg setupAckPulse,
  output reg stateReadPulse,
  output reg [3:0] stateReadIndex,
  output reg unlockPulse,
  output reg allocStart,
  output reg buffersInvalid,
  output reg [127:0] endpointSetupOut
);
  // access phase; a new command restarts the byte count unless a bus reset comes in the same cycle
  localparam [1:0] PH_IDLE = 2'd0;
  localparam [1:0] PH_WRITE = 2'd1;
  localparam [1:0] PH_READ = 2'd2;
  localparam [1:0] PH_DONE = 2'd3;
  // pins come from the processor side, so they are synchronised first
  reg [19:0] pinMeta_reg;
  reg [19:0] pinSync_reg;
  reg wrPrev_reg;
  reg rdPrev_reg;
  reg [7:0] cmd_reg;
  reg [2:0] byteIdx_reg;
  reg [7:0] setup_reg [0:15];
  reg [15:0] spare_reg;
  reg [15:0] unlockWord_reg;
  reg [3:0] cfgNext_reg;
  reg [2:0] busResetSync_reg;
  reg [1:0] phase_reg;
  reg [1:0] phase_next;
  wire [15:0] fifoOut;
  wire fifoValid;
  wire fifoInReady;
  reg [15:0] readWord;
  reg readPush;
  wire busReset = busResetSync_reg[1] && !busResetSync_reg[2];
  wire [15:0] pinData = pinSync_reg[15:0];
  wire pinSel = pinSync_reg[16];
  wire pinWr = pinSync_reg[17];
  wire pinRd = pinSync_reg[18];
  wire pinWide = pinSync_reg[19];
  wire wrEdge = pinWr && !wrPrev_reg;
  wire rdEdge = pinRd && !rdPrev_reg;
  wire [3:0] grp = cmd_reg[7:4];
  wire [3:0] ep = cmd_reg[3:0];
  // bytes moved by one strobe: two per word on the wide bus
  wire [2:0] step = pinWide ? 3'd2 : 3'd1;
  wire [2:0] idxAfter = byteIdx_reg + step;
  integer i;

  // byte of a wider register, least significant first
  function [7:0] pickByte;
    input [31:0] value;
    input [1:0] idx;
    begin
      pickByte = value[8*idx +: 8];
    end
  endfunction

  // register width in bytes for a read command, zero if none
  function [2:0] readLen;
    input [7:0] code;
    begin
      case (code[7:4])
        `UDCD_GRP_SETUP_RD, `UDCD_GRP_STATE, `UDCD_GRP_FAULT, `UDCD_GRP_COPY: readLen = 3'd1;
        default: begin
          if (code == `UDCD_CMD_SPARE_RD || code == `UDCD_CMD_FRAME ||
              code == `UDCD_CMD_IDENT) begin
            readLen = 3'd2;
          end else if (code == `UDCD_CMD_FLAGS) begin
            readLen = 3'd4;
          end else begin
            readLen = 3'd0;
          end
        end
      endcase
    end
  endfunction

  // register width in bytes for a write command, zero if none
  function [2:0] writeLen;
    input [7:0] code;
    begin
      case (code[7:4])
        `UDCD_GRP_SETUP_WR: writeLen = 3'd1;
        default: begin
          if (code == `UDCD_CMD_SPARE_WR || code == `UDCD_CMD_UNLOCK) begin
            writeLen = 3'd2;
          end else begin
            writeLen = 3'd0;
          end
        end
      endcase
    end
  endfunction

  // current read value of the command's register
  always @* begin
    readWord = 16'h0000;
    case (grp)
      `UDCD_GRP_SETUP_RD: readWord = {8'h00, setup_reg[ep]};
      `UDCD_GRP_STATE: readWord = {8'h00, endpointStateIn[8*ep +: 8]};
      `UDCD_GRP_FAULT: readWord = {8'h00, endpointFaultIn[8*ep +: 8]};
      `UDCD_GRP_COPY: readWord = {8'h00, endpointStateIn[8*ep +: 8]};
      default: begin
        if (cmd_reg == `UDCD_CMD_SPARE_RD) begin
          readWord = spare_reg;
        end else if (cmd_reg == `UDCD_CMD_FRAME) begin
          readWord = {5'h00, frameCount};
        end else if (cmd_reg == `UDCD_CMD_IDENT) begin
          readWord = PART_IDENTITY;
        end else if (cmd_reg == `UDCD_CMD_FLAGS) begin
          readWord = byteIdx_reg[1] ? eventFlags[31:16] : eventFlags[15:0];
        end
      end
    endcase
    // narrow registers and byte mode carry only the low byte
    if (readLen(cmd_reg) == 3'd1) begin
      readWord[15:8] = 8'h00;
    end else if (!pinWide) begin
      readWord = {8'h00, pickByte({readWord, readWord}, byteIdx_reg[0] ? 2'd1 : 2'd0)};
    end
  end

  // a read strobe pushes the next word; dropped when the fifo is full
  always @* begin
    readPush = rdEdge && !pinSel && !busReset && (phase_reg == PH_READ) && fifoInReady;
  end

  // strobes past the register width are refused until the next command
  always @* begin
    phase_next = phase_reg;
    if (busReset) begin
      // bus reset wins over a strobe in the same cycle
      phase_next = phase_reg;
    end else if (wrEdge && pinSel) begin
      if (readLen(pinData[7:0]) != 3'd0) begin
        phase_next = PH_READ;
      end else if (writeLen(pinData[7:0]) != 3'd0) begin
        phase_next = PH_WRITE;
      end else begin
        // no data phase follows; later data strobes are dropped
        phase_next = PH_DONE;
      end
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          phase_next = PH_IDLE;
        end
        PH_WRITE: begin
          if (wrEdge && !pinSel && idxAfter >= writeLen(cmd_reg)) begin
            phase_next = PH_DONE;
          end
        end
        PH_READ: begin
          if (readPush && idxAfter >= readLen(cmd_reg)) begin
            phase_next = PH_DONE;
          end
        end
        PH_DONE: begin
          phase_next = PH_DONE;
        end
        default: begin
          phase_next = PH_IDLE;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      phase_reg <= PH_IDLE;
    end else begin
      phase_reg <= phase_next;
    end
  end

  udcd_fifo #(
    .WIDTH(16),
    .DEPTH(`UDCD_FIFO_DEPTH),
    .AW(`UDCD_FIFO_AW)
  ) readFifo (
    .clk(clk),
    .reset(reset),
    .inData(readWord),
    .inValid(readPush),
    .inReady(fifoInReady),
    .outData(fifoOut),
    .outValid(fifoValid),
    .outReady(1'b1)
  );

  always @(posedge clk) begin
    if (reset) begin
      pinMeta_reg <= 20'h00000;
      pinSync_reg <= 20'h00000;
      busResetSync_reg <= 3'h0;
      wrPrev_reg <= 1'b0;
      rdPrev_reg <= 1'b0;
    end else begin
      pinMeta_reg <= {wide16, readStrobe, writeStrobe, cmdSelect, dataIn};
      pinSync_reg <= pinMeta_reg;
      busResetSync_reg <= {busResetSync_reg[1:0], usbBusReset};
      wrPrev_reg <= pinWr;
      rdPrev_reg <= pinRd;
    end
  end

  always @(posedge clk) begin
    if (reset) begin
      cmd_reg <= 8'h00;
      byteIdx_reg <= 3'd0;
      spare_reg <= `UDCD_SPARE_RESET;
      unlockWord_reg <= 16'h0000;
      cfgNext_reg <= 4'h0;
      validatePulse <= 16'h0000;
      clearPulse <= 16'h0000;
      unstallPulse <= 16'h0000;
      setupAckPulse <= 1'b0;
      stateReadPulse <= 1'b0;
      stateReadIndex <= 4'h0;
      unlockPulse <= 1'b0;
      allocStart <= 1'b0;
      buffersInvalid <= 1'b0;
      dataOut <= 16'h0000;
      dataOutValid <= 1'b0;
      for (i = 0; i < 16; i = i + 1) begin
        setup_reg[i] <= `UDCD_SETUP_RESET;
      end
    end else begin
      validatePulse <= 16'h0000;
      clearPulse <= 16'h0000;
      unstallPulse <= 16'h0000;
      setupAckPulse <= 1'b0;
      stateReadPulse <= 1'b0;
      unlockPulse <= 1'b0;
      allocStart <= 1'b0;
      buffersInvalid <= 1'b0;
      dataOutValid <= fifoValid;
      dataOut <= fifoValid ? fifoOut : 16'h0000;
      if (busReset) begin
        for (i = 0; i < 16; i = i + 1) begin
          setup_reg[i][`UDCD_BIT_ENABLE] <= 1'b0;
        end
        buffersInvalid <= 1'b1;
      end else if (wrEdge && pinSel) begin
        // upper byte of the command word is ignored
        cmd_reg <= pinData[7:0];
        byteIdx_reg <= 3'd0;
        // no data phase: act right away
        case (pinData[7:4])
          `UDCD_GRP_VALIDATE: begin
            // code 60 is illegal from the host and does nothing here
            if (pinData[3:0] != 4'h0) begin
              validatePulse[pinData[3:0]] <= 1'b1;
            end
          end
          `UDCD_GRP_CLEAR: begin
            if (pinData[3:0] != 4'h1) begin
              clearPulse[pinData[3:0]] <= 1'b1;
            end
          end
          `UDCD_GRP_UNSTALL: unstallPulse[pinData[3:0]] <= 1'b1;
          `UDCD_GRP_STATE: begin
            stateReadPulse <= 1'b1;
            stateReadIndex <= pinData[3:0];
          end
          default: begin
            if (pinData[7:0] == `UDCD_CMD_SETUP_ACK) begin
              setupAckPulse <= 1'b1;
            end
          end
        endcase
      end else if (wrEdge && !pinSel && phase_reg == PH_WRITE) begin
        // data phase write, least significant first
        byteIdx_reg <= idxAfter;
        if (grp == `UDCD_GRP_SETUP_WR && byteIdx_reg == 3'd0) begin
          setup_reg[ep] <= pinData[7:0];
          // size or enable change wipes every buffer
          if (setup_reg[ep][`UDCD_BIT_ENABLE] != pinData[7] ||
              setup_reg[ep][3:0] != pinData[3:0]) begin
            buffersInvalid <= 1'b1;
          end
          // only an unbroken 0..15 sequence starts allocation
          if (ep == cfgNext_reg) begin
            cfgNext_reg <= (ep == `UDCD_LAST_EP) ? 4'h0 : cfgNext_reg + 4'h1;
            if (ep == `UDCD_LAST_EP) begin
              allocStart <= 1'b1;
            end
          end else begin
            cfgNext_reg <= (ep == 4'h0) ? 4'h1 : 4'h0;
          end
        end else if (cmd_reg == `UDCD_CMD_SPARE_WR) begin
          if (pinWide) begin
            spare_reg <= pinData;
          end else if (byteIdx_reg == 3'd0) begin
            spare_reg[7:0] <= pinData[7:0];
          end else if (byteIdx_reg == 3'd1) begin
            spare_reg[15:8] <= pinData[7:0];
          end
        end else if (cmd_reg == `UDCD_CMD_UNLOCK) begin
          if (pinWide) begin
            unlockWord_reg <= pinData;
            unlockPulse <= (byteIdx_reg == 3'd0);
          end else if (byteIdx_reg == 3'd0) begin
            unlockWord_reg[7:0] <= pinData[7:0];
          end else if (byteIdx_reg == 3'd1) begin
            unlockWord_reg[15:8] <= pinData[7:0];
            unlockPulse <= 1'b1;
          end
        end
      end else if (readPush) begin
        byteIdx_reg <= idxAfter;
      end
    end
  end

  // flatten setup bytes so the rest of the chip can see them
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : setupView
      always @(posedge clk) begin
        if (reset) begin
          endpointSetupOut[8*g +: 8] <= `UDCD_SETUP_RESET;
        end else begin
          endpointSetupOut[8*g +: 8] <= setup_reg[g];
        end
      end
    end
  endgenerate
endmodule // udcd_command_decoder

// *** udcd_assertions.sv ***
// port assertions for the command decoder
`timescale 1ns/1ps
module udcd_assertions (
  input wire clk,
  input wire reset,
  input wire cmdSelect,
  input wire usbBusReset,
  input wire dataOutValid,
  input wire setupAckPulse,
  input wire unlockPulse,
  input wire allocStart,
  input wire buffersInvalid,
  input wire [15:0] validatePulse,
  input wire [15:0] clearPulse,
  input wire [15:0] unstallPulse,
  input wire [127:0] endpointSetupOut
);
  wire [15:0] enBits;
  genvar g;
  for (g = 0; g < 16; g = g + 1) begin : g_en
    assign enBits[g] = endpointSetupOut[8 * g + 7];
  end
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  out_validate_a: assert property (validatePulse[0] == 1'h0)
    else $error("validate pulse on control out");
  in_clear_a: assert property (clearPulse[1] == 1'h0)
    else $error("clear pulse on control in");
  single_endpoint_a: assert property (
    $onehot0(unstallPulse) && $onehot0(validatePulse) && $onehot0(clearPulse))
    else $error("several endpoints pulsed at once");
  cmd_phase_a: assert property (
    (validatePulse | clearPulse | unstallPulse) != 16'h0 || setupAckPulse |-> $past(cmdSelect, 2))
    else $error("command pulse without command phase");
  ack_single_a: assert property (setupAckPulse |=> !setupAckPulse)
    else $error("setup acknowledge longer than one cycle");
  read_data_a: assert property (dataOutValid |-> !cmdSelect)
    else $error("read word during command phase");
  alloc_data_a: assert property (allocStart |-> !$past(cmdSelect, 2))
    else $error("allocation outside a data write");
  unlock_data_a: assert property (unlockPulse |-> !$past(cmdSelect, 2))
    else $error("unlock outside a data write");
  reset_disable_a: assert property ($rose(usbBusReset) |-> ##[1:8] enBits == 16'h0)
    else $error("endpoint still enabled after bus reset");
  reset_inval_a: assert property ($rose(usbBusReset) |-> ##[1:8] buffersInvalid)
    else $error("no invalidate after bus reset");
endmodule // udcd_assertions
bind udcd_command_decoder udcd_assertions i_udcd_assertions (.clk, .reset, .cmdSelect,
  .usbBusReset, .dataOutValid, .setupAckPulse, .unlockPulse, .allocStart, .buffersInvalid,
  .validatePulse, .clearPulse, .unstallPulse, .endpointSetupOut);

// *** udcd_host_model.sv ***
// processor model driving command and data phases
`timescale 1ns/1ps
module udcd_host_model (
  input wire clk,
  input wire [15:0] dataOut,
  input wire dataOutValid,
  output logic cmdSelect = 1'h0,
  output logic writeStrobe = 1'h0,
  output logic readStrobe = 1'h0,
  output logic [15:0] dataIn = 16'h0,
  output logic [15:0] lastWord = 16'h0
);
  always @(posedge clk) begin
    if (dataOutValid) begin
      lastWord <= dataOut;
    end
  end
  // 4 clk high and 4 low: margin over the 3-clk pin minimum
  task automatic xfer(input logic sel, input logic rd, input logic [15:0] d);
    @(negedge clk);
    cmdSelect = sel;
    dataIn = d;
    writeStrobe = ~rd;
    readStrobe = rd;
    repeat (4) @(negedge clk);
    writeStrobe = 1'h0;
    readStrobe = 1'h0;
    dataIn = ~d; // released bus must not show stale data
    repeat (4) @(negedge clk);
  endtask
endmodule // udcd_host_model

// *** usb_device_command_decoder_tb.sv ***
// self-checking bench for the command decoder
`timescale 1ns/1ps
module usb_device_command_decoder_tb;
  localparam logic [15:0] IDENT = 16'h3c7e; // value is arbitrary
  typedef struct packed {logic [7:0] code; logic [52:0] exp;} udcd_row_t;
  logic clk = 1'h0;
  logic reset = 1'h1;
  logic wide16 = 1'h1;
  logic usbBusReset = 1'h0;
  logic clr = 1'h0;
  logic [127:0] stateIn = 128'hf1e2d3c4b5a69788796a5b4c3d2e1f00;
  logic [127:0] faultIn = 128'h0e1d2c3b4a59687786a5b4c3d2e1f0ff;
  logic [10:0] frame = 11'h5a3;
  logic [31:0] flags = 32'hc001d00d;
  logic [52:0] cap = 53'h0;
  wire [15:0] dataIn, dataOut, validatePulse, clearPulse, unstallPulse, lastWord;
  wire [127:0] endpointSetupOut;
  wire [3:0] stateReadIndex;
  wire cmdSelect, writeStrobe, readStrobe, dataOutValid, setupAckPulse, stateReadPulse;
  wire unlockPulse, allocStart, buffersInvalid;
  udcd_row_t rows [49];
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  always #5 clk = ~clk;
  udcd_host_model i_udcd_host_model (.clk, .dataOut, .dataOutValid, .cmdSelect, .writeStrobe,
    .readStrobe, .dataIn, .lastWord);
  udcd_command_decoder #(.PART_IDENTITY(IDENT)) i_udcd_command_decoder (.clk, .reset,
    .cmdSelect, .writeStrobe, .readStrobe, .wide16, .dataIn, .usbBusReset,
    .endpointStateIn(stateIn), .endpointFaultIn(faultIn), .frameCount(frame),
    .eventFlags(flags), .dataOut, .dataOutValid, .validatePulse, .clearPulse, .unstallPulse,
    .setupAckPulse, .stateReadPulse, .stateReadIndex, .unlockPulse, .allocStart,
    .buffersInvalid, .endpointSetupOut);
  task automatic test_done();
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  always @(posedge clk) begin
    cap <= clr ? 53'h0 : cap | {validatePulse, clearPulse, unstallPulse, setupAckPulse,
      stateReadPulse, unlockPulse, allocStart, buffersInvalid};
    cycles <= cycles + 1;
    if (cycles > 4000) begin
      err_total++;
      test_done();
    end
  end
  task automatic check(input string what, input logic [127:0] seen, input logic [127:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // junk upper byte proves the command uses the low byte only
  task automatic cmd(input logic [7:0] c);
    @(negedge clk);
    clr = 1'h1;
    @(negedge clk);
    clr = 1'h0;
    i_udcd_host_model.xfer(1'h1, 1'h0, {8'ha5, c});
  endtask
  task automatic wd(input logic [15:0] d);
    i_udcd_host_model.xfer(1'h0, 1'h0, d);
  endtask
  task automatic rd(input string what, input logic [15:0] exp);
    i_udcd_host_model.xfer(1'h0, 1'h1, 16'h0);
    check(what, lastWord, exp);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    reset = 1'h0;
    check("setup reset", endpointSetupOut, 128'h0);
    for (int e = 0; e < 16; e++) begin
      rows[e] = {8'h60 + 8'(e), 53'(e != 0) << (37 + e)};
      rows[16 + e] = {8'h70 + 8'(e), 53'(e != 1) << (21 + e)};
      rows[32 + e] = {8'h80 + 8'(e), 53'h1 << (5 + e)};
    end
    rows[48] = {8'hf4, 53'h10};
    foreach (rows[i]) begin
      cmd(rows[i].code);
      check("command pulses", cap, rows[i].exp);
    end
    cmd(8'h23);
    wd(16'hffb5);
    check("setup ep3", endpointSetupOut[31:24], 8'hb5);
    cmd(8'h33);
    rd("setup read", 16'h00b5);
    for (int e = 0; e < 16; e++) begin
      cmd(8'h20 + 8'(e));
      wd({8'h00, 8'h80 | 8'(e)});
      check("alloc start", cap[1], e == 15);
      check("invalidate", cap[0], 1'h1);
    end
    check("last setup", endpointSetupOut[127:120], 8'h8f);
    usbBusReset = 1'h1;
    repeat (8) @(negedge clk);
    usbBusReset = 1'h0;
    for (int e = 0; e < 16; e++) check("bus reset", endpointSetupOut[8 * e + 7], 1'h0);
    wide16 = 1'h0;
    cmd(8'hb2);
    wd(16'h0034);
    wd(16'h0012);
    cmd(8'hb3);
    rd("spare lsb", 16'h0034);
    rd("spare msb", 16'h0012);
    wide16 = 1'h1;
    cmd(8'hb2);
    wd(16'hbeef);
    cmd(8'hb3);
    rd("spare word", 16'hbeef);
    cmd(8'hb5);
    rd("identity", IDENT);
    cmd(8'hb4);
    rd("frame", {5'h0, frame});
    cmd(8'hc0);
    rd("flags low", flags[15:0]);
    rd("flags high", flags[31:16]);
    rd("flags past end", flags[31:16]);
    cmd(8'h55);
    rd("state", {8'h00, stateIn[47:40]});
    check("state pulse", {cap[3], stateReadIndex}, 5'h15);
    cmd(8'hd7);
    rd("state copy", {8'h00, stateIn[63:56]});
    check("copy pulse", cap[3], 1'h0);
    cmd(8'ha3);
    rd("fault", {8'h00, faultIn[31:24]});
    cmd(8'hb0);
    wd(16'h5aa5);
    check("unlock", cap[2], 1'h1);
    reset = 1'h1;
    repeat (5) @(negedge clk);
    reset = 1'h0;
    check("setup after reset", endpointSetupOut, 128'h0);
    cmd(8'hb3);
    rd("spare after reset", 16'h0000);
    test_done();
  end
endmodule // usb_device_command_decoder_tb
